/* File: vpw_bus_ctrl_and_errors_test.sv */
// self-checking bench of the vpw link register block
// assumes it is the only bus master and plays the protocol engine
`timescale 1ns/1ns
module vpw_bus_ctrl_and_errors_test;
	import vpwbc_pkg::*;
	logic core_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, tx_drive = 0;
	logic brk_level = 0, avs_waitrequest, bus_tx_pin, bus_rx_pin, rx_filtered;
	logic prescale_tick, quad_rate_diag, link_run, hold_reset, resync_req, rx_sleep;
	logic [9:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata;
	logic [3:0] avs_byteenable = 4'h1, rx = '0;
	logic [5:0] ev = '0;
	logic [11:0] brk_len_ticks;
	logic [4:0] loop_delay_select;
	vpwbc_byte_t phys_addr_bits, q;
	int err_total = 0, cmp_count = 0, n;
	int resync_seen = 0, rs0;
	always #20 core_clk = ~core_clk;
	vpwbc_top u_dut (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .bus_tx_pin,
		.bus_rx_pin, .tx_drive, .ev_tx_underflow_flag(ev[5]), .ev_rx_overflow_flag(ev[4]), .ev_tra(ev[3]),
		.ev_crc(ev[2]), .ev_ifd(ev[1]), .ev_ibd(ev[0]), .brk_level, .rx_sof(rx[0]),
		.rx_byte(rx[1]), .rx_bit(rx[2]), .eof_valid(rx[3]), .rx_filtered,
		.prescale_tick, .quad_rate_diag, .brk_len_ticks, .loop_delay_select,
		.phys_addr_bits, .link_run, .hold_reset, .engine_restart(), .queue_abort(),
		.resync_req, .rx_sleep);
	vpwbc_xcvr_model u_xcvr (.core_clk, .bus_tx_pin, .bus_rx_pin);
	// counts resync pulses so a one cycle pulse is never missed between compares
	always @(posedge core_clk) resync_seen <= resync_seen + (resync_req === 1'b1);
	////////////////////////////////////////
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request held until waitrequest is seen low at an edge
	task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		k = 0;
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge core_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		if (avs_waitrequest !== 1'b0) begin
			err_total++;
			tally_and_finish();
		end
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		acc(1'b1, idx, d);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		acc(1'b0, idx, 8'h00);
		chk(q, e);
	endtask
	task automatic pulse(input logic [3:0] m);
		rx <= m;
		@(posedge core_clk);
		rx <= '0;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic frame(input int nb);
		pulse(4'h1);
		repeat (nb) pulse(4'h2);
		pulse(4'h4);
	endtask
	task automatic wait_tick();
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (prescale_tick !== 1'b1 && n < 200);
	endtask
	// tx held active until the timeout pulls it down
	task automatic tto_run(input int lim, input logic [7:0] cfg);
		wr(8'hf4, cfg);
		wr(8'hf5, 8'h80);
		tx_drive <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(bus_tx_pin, 1'b1);
		n = 0;
		while (bus_tx_pin === 1'b1 && n < lim + 50) begin
			@(posedge core_clk);
			n++;
		end
		chk(n >= lim - 6 && n <= lim + 2, 1);
		tx_drive <= 1'b0;
		rd(8'hf7, 8'h80);
		rd(8'hf7, 8'h80);
		chk(link_run, 1'b0);
		wr(8'hf5, 8'h00);
		rd(8'hf7, 8'h00);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(8'hf4, 8'h00);
		rd(8'hf5, 8'h40);
		rd(8'hf7, 8'h00);
		chk(rx_filtered, 1'b0);
		wr(8'hf4, 8'hff);
		rd(8'hf4, 8'hbf);
		chk({quad_rate_diag, brk_len_ticks}, 13'h14b0);
		wr(8'hf4, 8'h00);
		chk({quad_rate_diag, brk_len_ticks}, 13'h012c);
		wr(8'hf5, 8'h80);
		rd(8'hf5, 8'h00);
		wr(8'hf5, 8'h9f);
		rd(8'hf5, 8'h9f);
		chk(loop_delay_select, 5'h1f);
		repeat (8) @(posedge core_clk);
		chk({link_run, rx_filtered}, 2'h3);
		wr(8'hf6, 8'h5a);
		avs_byteenable <= 4'h0;
		wr(8'hf6, 8'hff);
		avs_byteenable <= 4'h1;
		rd(8'hf6, 8'h5a);
		chk(phys_addr_bits, 8'h5a);
		wr(8'hf8, 8'hff);
		rd(8'hf8, 8'h00);
		for (int i = 0; i < 6; i++) begin
			ev <= 6'h01 << i;
			repeat (2) @(posedge core_clk);
			ev <= '0;
			rd(8'hf7, (i < 3) ? (8'h01 << i) : (8'h02 << i));
			rd(8'hf7, 8'h00);
		end
		brk_level <= 1'b1;
		repeat (2) @(posedge core_clk);
		rd(8'hf7, 8'h08);
		rd(8'hf7, 8'h08);
		brk_level <= 1'b0;
		rd(8'hf7, 8'h08);
		rd(8'hf7, 8'h00);
		pulse(4'h8);
		frame(11);
		rd(8'hf7, 8'h00);
		pulse(4'h8);
		frame(12);
		rd(8'hf7, 8'h02);
		chk(rx_sleep, 1'b1);
		pulse(4'h8);
		chk(rx_sleep, 1'b0);
		wr(8'hf5, 8'hbf);
		frame(12);
		rd(8'hf7, 8'h00);
		pulse(4'h8);
		ev <= 6'h08;
		repeat (2) @(posedge core_clk);
		ev <= '0;
		wr(8'hf5, 8'h40);
		rd(8'hf7, 8'h00);
		chk({link_run, hold_reset}, 2'h1);
		wr(8'hf5, 8'h00);
		for (int f = 0; f < 64; f += 21) begin
			rs0 = resync_seen;
			wr(8'hf4, 8'(f));
			repeat (3) wait_tick();
			chk(n, f + 1);
			chk(resync_seen - rs0, f != 0);
		end
		tto_run(1000, 8'h00);
		tto_run(4000, 8'h80);
		tally_and_finish();
	end
endmodule

/* File: vpwbc_params.svh */
// register offsets, field positions, reset values and timing counts of the vpw link block
// assumes a 25 MHz core clock and a prescaled tick of nominally 1 MHz
// Function
// - quad mode keeps break and timeout nominal
// - core clock equals 1 MHz times field plus one
// - prescale change may require bus resync
// - disabled: tx passive, rx ignored
// - enable clear aborts queue; freeze clears enable
// - freeze stops decoding; release restarts engines
// - freeze holds status, errors, masks at reset
// - over twelve bytes: invalid frame, sleep
// - length check disable removes the limit
// - loop delay select 0 to 31 us
// - in-frame responses send physical address
// - error read clears flags except timeout, and break while brk_level is held
// - errors sampled per tick, end at eof
// - aborted request only sets its flag
// - timeout after 1000 or 4000 active ticks
// - timeout forces pin passive until enable cleared
`ifndef VPWBC_PARAMS_SVH
`define VPWBC_PARAMS_SVH
`define VPWBC_IDX_PRESCALE 8'hf4
`define VPWBC_IDX_CONTROL  8'hf5
`define VPWBC_IDX_PADDR    8'hf6
`define VPWBC_IDX_ERROR    8'hf7
`define VPWBC_RST_PRESCALE 8'h00
`define VPWBC_RST_CONTROL  8'h40
`define VPWBC_RST_ERROR    8'h00
`define VPWBC_B_QUAD       7
`define VPWBC_B_JE         7
`define VPWBC_B_FREEZE     6
`define VPWBC_B_NFL        5
`define VPWBC_E_TTO        7
`define VPWBC_E_TX_UNDERFLOW_FLAG       6
`define VPWBC_E_RX_OVERFLOW_FLAG       5
`define VPWBC_E_TRA        4
`define VPWBC_E_RX_BREAK_FLAG       3
`define VPWBC_E_CRC_ERROR_FLAG       2
`define VPWBC_E_IFD        1
`define VPWBC_E_IBD        0
`define VPWBC_TICK_MHZ     1
`define VPWBC_BRK_TIME_US  300
`define VPWBC_TTO_TIME_US  1000
`define VPWBC_QUAD_FACTOR  4
`define VPWBC_BRK_TICKS    (`VPWBC_BRK_TIME_US * `VPWBC_TICK_MHZ)
`define VPWBC_TTO_TICKS    (`VPWBC_TTO_TIME_US * `VPWBC_TICK_MHZ)
`define VPWBC_MAX_BYTES    12
`endif

/* File: vpwbc_pkg.sv */
// types shared by the vpw link block
// assumes the params header supplies all numeric constants
package vpwbc_pkg;
	typedef logic [7:0] vpwbc_byte_t;
	typedef enum logic [1:0] {
		VPWBC_IDLE  = 2'b00,
		VPWBC_FRAME = 2'b01,
		VPWBC_SLEEP = 2'b11
	} vpwbc_frame_e;
endpackage

/* File: vpwbc_tick.sv */
// prescaler: one tick every div+1 core clocks
// assumes div is stable; a change keeps the count, which wraps at once if already at or past the new div
`timescale 1ns/1ns
module vpwbc_tick #(
	parameter int unsigned W = 6
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         run,
	input  wire logic [W-1:0] div,
	output logic              tick
);
	logic [W-1:0] cnt_ff;
	logic         tick_ff;
	wire          wrap = (cnt_ff >= div);
	wire  [W-1:0] nxt_cnt = wrap ? {W{1'b0}} : cnt_ff + {{(W-1){1'b0}}, 1'b1};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= run ? nxt_cnt : '0;
			tick_ff <= run & wrap;
		end
	end
	assign tick = tick_ff;
endmodule

/* File: vpwbc_top.sv */
// configuration, control and error register block of the vpw byte level decoder
// assumes an avalon-mm master with byte addresses and a protocol engine on core_clk
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ns
`include "vpwbc_params.svh"
module vpwbc_top #(
	parameter int unsigned ADDR_W = 10
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic [ADDR_W-1:0]    avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic [31:0]               avs_readdata,
	output logic                      avs_waitrequest,
	output logic                      bus_tx_pin,
	input  wire logic                 bus_rx_pin,
	input  wire logic                 tx_drive,
	input  wire logic                 ev_tx_underflow_flag,
	input  wire logic                 ev_rx_overflow_flag,
	input  wire logic                 ev_tra,
	input  wire logic                 ev_crc,
	input  wire logic                 ev_ibd,
	input  wire logic                 ev_ifd,
	input  wire logic                 brk_level,
	input  wire logic                 rx_sof,
	input  wire logic                 rx_bit,
	input  wire logic                 rx_byte,
	input  wire logic                 eof_valid,
	output logic                      rx_filtered,
	output logic                      prescale_tick,
	output logic                      quad_rate_diag,
	output logic [11:0]               brk_len_ticks,
	output logic [4:0]                loop_delay_select,
	output vpwbc_pkg::vpwbc_byte_t    phys_addr_bits,
	output logic                      link_run,
	output logic                      hold_reset,
	output logic                      engine_restart,
	output logic                      queue_abort,
	output logic                      resync_req,
	output logic                      rx_sleep
);
	import vpwbc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// reset release and pin synchroniser

	logic       rst_a_ff;
	logic       rst_b_ff;
	wire        rst_sync_n = rst_b_ff;
	logic [2:0] rx_sync_ff;
	logic       rx_flt_ff;

	// assert at once, release two edges later so every flop leaves reset on one edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_a_ff <= 1'b0;
			rst_b_ff <= 1'b0;
		end else begin
			rst_a_ff <= 1'b1;
			rst_b_ff <= rst_a_ff;
		end
	end

	// only stage two and three are compared, stage one feeds stage two alone
	wire rx_agree = (rx_sync_ff[1] == rx_sync_ff[2]);

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rx_sync_ff <= 3'h0;
			rx_flt_ff  <= 1'b0;
		end else begin
			rx_sync_ff <= {rx_sync_ff[1:0], bus_rx_pin};
			if (rx_agree) begin
				rx_flt_ff <= rx_sync_ff[2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, then waitrequest low for one cycle

	logic        wreq_ff;
	logic [31:0] rdata_ff;
	logic [7:0]  presc_ff;
	logic        je_ff;
	logic        freeze_ff;
	logic        nfl_ff;
	logic [4:0]  jdly_ff;
	logic [7:0]  paddr_ff;
	logic [7:0]  err_ff;

	wire       req      = avs_read | avs_write;
	wire [7:0] idx      = avs_address[9:2];
	wire       hit_psc  = (idx == `VPWBC_IDX_PRESCALE);
	wire       hit_ctl  = (idx == `VPWBC_IDX_CONTROL);
	wire       hit_pad  = (idx == `VPWBC_IDX_PADDR);
	wire       hit_err  = (idx == `VPWBC_IDX_ERROR);
	wire       commit   = req & ~wreq_ff;
	wire       wr_en    = commit & avs_write & avs_byteenable[0];
	wire       wr_psc   = wr_en & hit_psc;
	wire       wr_ctl   = wr_en & hit_ctl;
	wire       wr_pad   = wr_en & hit_pad;
	wire       rd_err   = commit & avs_read & hit_err;
	wire [7:0] ctl_view = {je_ff, freeze_ff, nfl_ff, jdly_ff};
	wire [7:0] psc_view = {presc_ff[7], 1'b0, presc_ff[5:0]};
	wire [7:0] rd_mux   = hit_psc ? psc_view :
	                      hit_ctl ? ctl_view :
	                      hit_pad ? paddr_ff :
	                      hit_err ? err_ff   : 8'h00;

	// readdata is captured in the wait cycle and held until the next access
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wreq_ff  <= 1'b1;
			rdata_ff <= 32'h0;
		end else begin
			wreq_ff <= ~(req & wreq_ff);
			if (req & wreq_ff) begin
				rdata_ff <= {24'h0, rd_mux};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration and control registers

	wire [7:0] wd8     = avs_writedata[7:0];
	wire [7:0] nxt_psc = {wd8[`VPWBC_B_QUAD], 1'b0, wd8[5:0]};
	logic      tto_ff;
	wire       run     = je_ff & ~freeze_ff & ~tto_ff;
	// the freeze bit set in this write or already set keeps enable low
	wire       nxt_je  = wd8[`VPWBC_B_JE] & ~wd8[`VPWBC_B_FREEZE] & ~freeze_ff;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			presc_ff  <= `VPWBC_RST_PRESCALE;
			je_ff     <= 1'b0;
			freeze_ff <= 1'b1;
			nfl_ff    <= 1'b0;
			jdly_ff   <= 5'h00;
			paddr_ff  <= 8'h00;
		end else begin
			if (wr_psc) begin
				presc_ff <= nxt_psc;
			end
			if (wr_ctl) begin
				je_ff     <= nxt_je;
				freeze_ff <= wd8[`VPWBC_B_FREEZE];
				nfl_ff    <= wd8[`VPWBC_B_NFL];
				jdly_ff   <= wd8[4:0];
			end
			if (wr_pad) begin
				paddr_ff <= wd8;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// prescaler, tick runs only while the peripheral clock is not frozen

	logic tick;

	// quad mode leaves the divider alone, software loads the faster value itself
	vpwbc_tick #(
		.W (6)
	) u_tick (
		.clk   (core_clk),
		.rst_n (rst_sync_n),
		.run   (~freeze_ff),
		.div   (presc_ff[5:0]),
		.tick  (tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// transmit pin and timeout watchdog

	logic [11:0] tto_cnt_ff;
	logic        tx_ff;
	wire         quad     = presc_ff[`VPWBC_B_QUAD];
	wire [11:0]  tto_nom  = 12'(`VPWBC_TTO_TICKS);
	wire [11:0]  tto_quad = 12'(`VPWBC_TTO_TICKS * `VPWBC_QUAD_FACTOR);
	// a quad rate tick is four times shorter, so four times the count keeps one millisecond
	wire [11:0]  tto_lim  = quad ? tto_quad : tto_nom;
	wire         tto_hit  = tx_ff & tick & (tto_cnt_ff == tto_lim - 12'h001);
	wire [11:0]  nxt_tcnt = ~tx_ff ? 12'h000 :
	                        (tick & ~tto_ff) ? tto_cnt_ff + 12'h001 : tto_cnt_ff;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tx_ff      <= 1'b0;
			tto_cnt_ff <= 12'h000;
			tto_ff     <= 1'b0;
		end else begin
			// pin goes passive the cycle the timeout trips
			tx_ff      <= run & ~tto_hit & tx_drive;
			tto_cnt_ff <= nxt_tcnt;
			if (~je_ff | freeze_ff) begin
				tto_ff <= 1'b0;
			end else if (tto_hit) begin
				tto_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// frame length check and sleep until eof

	vpwbc_frame_e fst_ff;
	vpwbc_frame_e nxt_fst;
	logic [3:0]   bcnt_ff;
	wire          len_over = run & ~nfl_ff & (fst_ff == VPWBC_FRAME) & rx_bit &
	                         (bcnt_ff == 4'(`VPWBC_MAX_BYTES));
	wire          cond_ev  = tick & run & (ev_crc | ev_ibd | ev_ifd | brk_level);
	// the byte count saturates so a long frame with the check off never wraps
	wire          bsat     = (bcnt_ff == 4'hf);
	wire [3:0]    nxt_bcnt = (rx_sof & (fst_ff == VPWBC_IDLE)) ? 4'h0 :
	                         (rx_byte & ~bsat) ? bcnt_ff + 4'h1 : bcnt_ff;

	always_comb begin
		nxt_fst = fst_ff;
		case (fst_ff)
			VPWBC_IDLE: begin
				if (cond_ev) begin
					nxt_fst = VPWBC_SLEEP;
				end else if (rx_sof & run) begin
					nxt_fst = VPWBC_FRAME;
				end
			end
			VPWBC_FRAME: begin
				if (len_over | cond_ev) begin
					nxt_fst = VPWBC_SLEEP;
				end else if (eof_valid) begin
					nxt_fst = VPWBC_IDLE;
				end
			end
			VPWBC_SLEEP: begin
				if (eof_valid) begin
					nxt_fst = VPWBC_IDLE;
				end
			end
			default: begin
				nxt_fst = VPWBC_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fst_ff  <= VPWBC_IDLE;
			bcnt_ff <= 4'h0;
		end else begin
			fst_ff  <= run ? nxt_fst : VPWBC_IDLE;
			bcnt_ff <= run ? nxt_bcnt : 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// error register, set wins over the read clear

	wire       tk      = tick & run;
	wire [7:0] err_set = {tto_hit,
	                      tk & ev_tx_underflow_flag,
	                      tk & ev_rx_overflow_flag,
	                      tk & ev_tra,
	                      tk & brk_level,
	                      tk & ev_crc,
	                      (tk & ev_ifd) | len_over,
	                      tk & ev_ibd};
	// the clear works on the image this read captured, so a flag that lands
	// between capture and commit is kept for the next read
	wire [7:0] clr_keep = {1'b1, 3'h0, brk_level, 3'h0};
	wire [7:0] rd_clr  = rd_err ? (rdata_ff[7:0] & ~clr_keep) : 8'h00;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			err_ff <= `VPWBC_RST_ERROR;
		end else if (~je_ff | freeze_ff) begin
			err_ff <= `VPWBC_RST_ERROR;
		end else begin
			err_ff <= (err_ff & ~rd_clr) | err_set;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs to the protocol engine

	logic        run_ff;
	logic        frz_q_ff;
	logic        restart_ff;
	logic        abort_ff;
	logic        resync_ff;
	logic        rxo_ff;
	logic        sleep_ff;
	logic        tick_ff;
	logic [11:0] brk_ff;
	wire         psc_chg = wr_psc & (nxt_psc != presc_ff);
	wire  [11:0] brk_nom  = 12'(`VPWBC_BRK_TICKS);
	wire  [11:0] brk_quad = 12'(`VPWBC_BRK_TICKS * `VPWBC_QUAD_FACTOR);
	// abort and restart are one cycle pulses; the engine acts on the pulse, not a level

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			run_ff     <= 1'b0;
			frz_q_ff   <= 1'b1;
			restart_ff <= 1'b0;
			abort_ff   <= 1'b0;
			resync_ff  <= 1'b0;
			rxo_ff     <= 1'b0;
			sleep_ff   <= 1'b0;
			tick_ff    <= 1'b0;
			brk_ff     <= 12'(`VPWBC_BRK_TICKS);
		end else begin
			run_ff     <= run;
			frz_q_ff   <= freeze_ff;
			restart_ff <= frz_q_ff & ~freeze_ff;
			abort_ff   <= run_ff & ~run;
			resync_ff  <= psc_chg;
			rxo_ff     <= run & rx_flt_ff;
			sleep_ff   <= (fst_ff == VPWBC_SLEEP);
			tick_ff    <= tick;
			brk_ff     <= quad ? brk_quad : brk_nom;
		end
	end

	assign avs_readdata      = rdata_ff;
	assign avs_waitrequest   = wreq_ff;
	assign bus_tx_pin        = tx_ff;
	assign rx_filtered       = rxo_ff;
	assign prescale_tick     = tick_ff;
	assign quad_rate_diag    = presc_ff[`VPWBC_B_QUAD];
	assign brk_len_ticks     = brk_ff;
	assign loop_delay_select = jdly_ff;
	assign phys_addr_bits    = paddr_ff;
	assign link_run          = run_ff;
	assign hold_reset        = freeze_ff;
	assign engine_restart    = restart_ff;
	assign queue_abort       = abort_ff;
	assign resync_req        = resync_ff;
	assign rx_sleep          = sleep_ff;
endmodule

/* File: vpwbc_top_assertions.sv */
// concurrent checks on the ports of the vpw link register block
// assumes one core clock and requests held until waitrequest falls
`timescale 1ns/1ns
module vpwbc_top_assertions #(
	parameter int unsigned ADDR_W = 10
) (
	input wire logic              core_clk,
	input wire logic              rst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic              avs_read,
	input wire logic              avs_waitrequest,
	input wire logic [31:0]       avs_readdata,
	input wire logic              bus_tx_pin,
	input wire logic              rx_bit,
	input wire logic              ev_crc,
	input wire logic              ev_ibd,
	input wire logic              ev_ifd,
	input wire logic              brk_level,
	input wire logic              rx_filtered,
	input wire logic              quad_rate_diag,
	input wire logic [11:0]       brk_len_ticks,
	input wire logic              link_run,
	input wire logic              hold_reset,
	input wire logic              engine_restart,
	input wire logic              queue_abort,
	input wire logic              rx_sleep
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// three idle cycles cover the one cycle lag between run and its copy
	tx_passive_a: assert property ((!link_run) [*3] |-> !bus_tx_pin)
		else $error("tx pin active while stopped");
	rx_gate_a: assert property ((!link_run) [*3] |-> !rx_filtered)
		else $error("rx passed while stopped");
	quad_brk_a: assert property ($stable(quad_rate_diag) |->
		brk_len_ticks == (quad_rate_diag ? 12'h4b0 : 12'h12c))
		else $error("break length wrong");
	reserved_a: assert property (avs_read && avs_waitrequest &&
		avs_address[ADDR_W-1:2] == 8'hf4 |=> !avs_waitrequest && !avs_readdata[6])
		else $error("prescale read wrong");
	freeze_stop_a: assert property (hold_reset [*3] |-> !link_run)
		else $error("running while frozen");
	restart_a: assert property ($fell(hold_reset) |-> ##[0:3] engine_restart)
		else $error("no restart after unfreeze");
	abort_a: assert property ($fell(link_run) |-> ##[0:3] queue_abort)
		else $error("no queue abort");
	// sleep comes from a length overrun or a tick-qualified error condition, two edges back
	sleep_a: assert property ($rose(rx_sleep) |-> $past(rx_bit, 2) ||
		$past(ev_crc || ev_ibd || ev_ifd || brk_level, 2))
		else $error("sleep without cause");
endmodule
bind vpwbc_top vpwbc_top_assertions #(.ADDR_W(ADDR_W)) u_chk (.core_clk, .rst_n,
	.avs_address, .avs_read, .avs_waitrequest, .avs_readdata, .bus_tx_pin, .rx_bit,
	.ev_crc, .ev_ibd, .ev_ifd, .brk_level,
	.rx_filtered, .quad_rate_diag, .brk_len_ticks, .link_run, .hold_reset,
	.engine_restart, .queue_abort, .rx_sleep);

/* File: vpwbc_xcvr_model.sv */
// bus transceiver stand-in: echoes the tx pin, inverted, after the loop delay
// assumes the delay is counted in core clocks; bus idles high by pull-up
`timescale 1ns/1ns
module vpwbc_xcvr_model #(
	parameter int unsigned DLY = 3
) (
	input  wire logic core_clk,
	input  wire logic bus_tx_pin,
	output logic      bus_rx_pin
);
	logic [DLY-1:0] line_ff = '0;
	always_ff @(posedge core_clk) begin
		line_ff <= {line_ff[DLY-2:0], bus_tx_pin};
	end
	assign bus_rx_pin = !line_ff[DLY-1];
endmodule
